// ===== rtl/flash_config_word_decoder.sv
// boot-time flash configuration word decoder with user-mode access checker
// assumes words are loaded by a boot loader on core_clk, and a plain register port
//
// Summary of operation
// R1 - boundary word upper half complements lower
// R2 - lower half gives data space base
// R3 - base low nine bits forced zero
// R4 - base below 200h treated as 200h
// R5 - debug code 55h disables debug port
// R6 - debug code complement mismatch disables debug
// R7 - permission words checked against complement half
// R8 - failed permission word means fully protected
// R9 - low read word: bit n, block n
// R10 - high read word covers upper 32 KB
// R11 - cleared bit blocks user-mode reads there
// R12 - separate checked write words, low and high 32 KB
// R13 - write bit set allows, cleared blocks
`timescale 1ns/1ps
module flash_config_word_decoder
   import flash_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire cfg_load_type cfg_load,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rd_data,
   input wire flash_req_type flash_req,
   output logic access_done,
   output logic access_allowed,
   output logic debug_port_enable,
   output logic [15:0] data_space_base
);

   logic [31:0] cfg_word [word_count];
   logic user_mode;

   logic boundary_ok;
   logic [15:0] aligned_base;
   logic [15:0] next_base;
   logic debug_ok;
   logic [7:0] debug_code;
   logic next_debug_enable;

   logic [permit_count-1:0] permit_ok;
   logic [15:0] permit [permit_count];
   logic [15:0] read_low_permit;
   logic [15:0] read_high_permit;
   logic [15:0] write_low_permit;
   logic [15:0] write_high_permit;

   logic [31:0] status_word;
   logic [31:0] next_rd_data;
   logic read_permit;
   logic write_permit;
   logic next_allowed;

   // pick the block bit for an address from a low/high pair of words
   function automatic logic block_permit(input logic [15:0] low_word,
                                         input logic [15:0] high_word,
                                         input logic [15:0] addr);
      logic [15:0] half_word;
      half_word = addr[half_bit] ? high_word : low_word;
      return half_word[addr[half_bit-1:block_lsb]];
   endfunction

   // map a bus byte address to a stored word index
   function automatic logic [3:0] word_index(input logic [31:0] addr);
      logic [3:0] hit_idx;
      hit_idx = 4'h0;
      unique case (addr)
         off_boundary:
         begin
            hit_idx = {1'b1, idx_boundary};
         end
         off_debug_lock:
         begin
            hit_idx = {1'b1, idx_debug_lock};
         end
         off_read_low:
         begin
            hit_idx = {1'b1, idx_read_low};
         end
         off_read_high:
         begin
            hit_idx = {1'b1, idx_read_high};
         end
         off_write_low:
         begin
            hit_idx = {1'b1, idx_write_low};
         end
         off_write_high:
         begin
            hit_idx = {1'b1, idx_write_high};
         end
         default:
         begin
            hit_idx = 4'h0;
         end
      endcase
      return hit_idx;
   endfunction

   // block-local registers match on the whole address, so aliases never hit
   function automatic logic local_hit(input logic [31:0] addr,
                                      input logic [31:0] offset);
      return (addr == offset);
   endfunction

   // configuration word storage, filled by the boot loader
   // sel 6 and 7 address nothing and are dropped
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < word_count; i++)
         begin
            cfg_word[i] <= word_reset;
         end
      end
      else if (cfg_load.strobe && (cfg_load.sel <= idx_write_high))
      begin
         cfg_word[cfg_load.sel] <= cfg_load.data;
      end
   end

   // control register: the only software-writable state
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         user_mode <= control_user_mode_reset;
      end
      else if (reg_wr && local_hit(reg_addr, off_control))
      begin
         user_mode <= reg_wr_data[ctrl_user_mode_bit];
      end
   end

   // data space boundary
   always_comb
   begin
      boundary_ok = (cfg_word[idx_boundary][31:16] == ~cfg_word[idx_boundary][15:0]); // R1
      // a corrupt word falls back to the smallest application space
      aligned_base = boundary_ok ? (cfg_word[idx_boundary][15:0] & base_align_mask) // R2 R3
                                 : base_minimum;
      next_base = (aligned_base < base_minimum) ? base_minimum : aligned_base; // R4
   end

   // output lags the stored word by one cycle so the pin stays on a flop
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         data_space_base <= base_minimum;
      end
      else
      begin
         data_space_base <= next_base;
      end
   end

   // debug port enable
   // reserved bytes are left unchecked, only the code and its complement count
   always_comb
   begin
      debug_code = cfg_word[idx_debug_lock][debug_code_lsb +: 8];
      debug_ok = (cfg_word[idx_debug_lock][debug_check_lsb +: 8] == ~debug_code); // R6
      next_debug_enable = debug_ok && (debug_code != debug_disable_code); // R5 R6
   end

   // locked until a good word says otherwise
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         debug_port_enable <= debug_enable_reset;
      end
      else
      begin
         debug_port_enable <= next_debug_enable;
      end
   end

   // permission words, each checked on its own
   generate
      for (genvar g = 0; g < permit_count; g++)
      begin : g_permit
         permit_word_check u_check (
            .word(cfg_word[g + 32'(idx_read_low)]),
            .word_ok(permit_ok[g]),
            .permit(permit[g])
         ); // R7 R8 R12
      end
   endgenerate

   // named views, in the storage order of the permission words
   always_comb
   begin
      read_low_permit = permit[2'(idx_read_low - idx_read_low)];
      read_high_permit = permit[2'(idx_read_high - idx_read_low)];
      write_low_permit = permit[2'(idx_write_low - idx_read_low)];
      write_high_permit = permit[2'(idx_write_high - idx_read_low)];
   end

   // user-mode access check; outside user mode the whole array is open
   always_comb
   begin
      read_permit = block_permit(read_low_permit, read_high_permit, flash_req.addr); // R9 R10 R11
      write_permit = block_permit(write_low_permit, write_high_permit, flash_req.addr); // R12 R13
      if (!user_mode)
      begin
         next_allowed = 1'b1;
      end
      else if (flash_req.write)
      begin
         next_allowed = write_permit; // R13
      end
      else
      begin
         next_allowed = read_permit; // R11
      end
   end

   // answer one cycle after the request; held until the next request
   // reset verdict is a refusal, like the all-protected reset words
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         access_allowed <= access_reset;
      end
      else if (flash_req.valid)
      begin
         access_allowed <= next_allowed;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         access_done <= access_reset;
      end
      else
      begin
         access_done <= flash_req.valid;
      end
   end

   // status shows the decoded state, not the raw words
   // unlagged, so software sees a new word one cycle before the registered outputs
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[15:0] = next_base;
      status_word[st_debug_enable_bit] = next_debug_enable;
      status_word[st_boundary_ok_bit] = boundary_ok;
      status_word[st_debug_ok_bit] = debug_ok;
      status_word[st_permit_ok_lsb +: permit_count] = permit_ok;
   end

   // read mux; unmapped addresses read zero
   always_comb
   begin
      logic [3:0] hit_idx;
      hit_idx = word_index(reg_addr);
      next_rd_data = 32'h0000_0000;
      if (hit_idx[3])
      begin
         next_rd_data = cfg_word[hit_idx[2:0]];
      end
      else if (local_hit(reg_addr, off_control))
      begin
         next_rd_data[ctrl_user_mode_bit] = user_mode;
      end
      else if (local_hit(reg_addr, off_status))
      begin
         next_rd_data = status_word;
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rd_data <= rd_data_reset;
      end
      else if (reg_rd)
      begin
         reg_rd_data <= next_rd_data;
      end
      else
      begin
         reg_rd_data <= 32'h0000_0000;
      end
   end

endmodule

// ===== rtl/flash_cfg_pkg.sv
// constants, field layouts and carriers for the flash configuration word decoder
// assumes one clock domain; words arrive from a boot loader on the same clock
package flash_cfg_pkg;

   // printed byte addresses of the configuration words
   localparam logic [31:0] off_boundary = 32'h0030_0008;
   localparam logic [31:0] off_debug_lock = 32'h0030_000c;
   localparam logic [31:0] off_read_low = 32'h0030_0200;
   localparam logic [31:0] off_read_high = 32'h0030_0204;
   localparam logic [31:0] off_write_low = 32'h0030_0208;
   localparam logic [31:0] off_write_high = 32'h0030_020c;
   // block-local registers
   localparam logic [31:0] off_control = 32'h0030_0300;
   localparam logic [31:0] off_status = 32'h0030_0304;

   // storage index of each word
   localparam logic [2:0] idx_boundary = 3'h0;
   localparam logic [2:0] idx_debug_lock = 3'h1;
   localparam logic [2:0] idx_read_low = 3'h2;
   localparam logic [2:0] idx_read_high = 3'h3;
   localparam logic [2:0] idx_write_low = 3'h4;
   localparam logic [2:0] idx_write_high = 3'h5;
   localparam int word_count = 6;
   localparam int permit_count = 4;

   // reset values: an all-zero word fails every complement check
   localparam logic [31:0] word_reset = 32'h0000_0000;
   localparam logic control_user_mode_reset = 1'b1;
   localparam logic [31:0] rd_data_reset = 32'h0000_0000;
   localparam logic debug_enable_reset = 1'b0;
   localparam logic access_reset = 1'b0;

   // boundary word layout
   localparam logic [15:0] base_minimum = 16'h0200;
   localparam logic [15:0] base_align_mask = 16'hfe00;

   // debug lock word layout
   localparam int debug_code_lsb = 8;
   localparam int debug_check_lsb = 24;
   localparam logic [7:0] debug_disable_code = 8'h55;

   // flash address layout: 2 KB blocks, top bit picks the half
   localparam int block_lsb = 11;
   localparam int half_bit = 15;

   // control and status fields
   localparam int ctrl_user_mode_bit = 0;
   localparam int st_debug_enable_bit = 16;
   localparam int st_boundary_ok_bit = 17;
   localparam int st_debug_ok_bit = 18;
   localparam int st_permit_ok_lsb = 19;

   typedef struct packed {
      logic strobe;
      logic [2:0] sel;
      logic [31:0] data;
   } cfg_load_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
   } flash_req_type;

endpackage

// ===== rtl/permit_word_check.sv
// complement check of one permission word
// assumes a stable word from the decoder's storage; purely combinational
`timescale 1ns/1ps
module permit_word_check
   import flash_cfg_pkg::*;
(
   input wire logic [31:0] word,
   output logic word_ok,
   output logic [15:0] permit
);

   assign word_ok = (word[31:16] == ~word[15:0]); // R7

   // failed check means nothing is allowed
   assign permit = word_ok ? word[15:0] : 16'h0000; // R8

endmodule

// ===== bench/flash_config_word_decoder_asserts.sv
// port assertions for the flash config word decoder
// bound onto the decoder; sees its ports only
`timescale 1ns/1ps
module flash_config_word_decoder_asserts
   import flash_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire cfg_load_type cfg_load,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rd_data,
   input wire flash_req_type flash_req,
   input wire logic access_done,
   input wire logic access_allowed,
   input wire logic debug_port_enable,
   input wire logic [15:0] data_space_base
);
   logic [15:0] al;
   logic [15:0] want_base;
   logic want_dbg;
   assign al = cfg_load.data[15:0] & base_align_mask;
   assign want_base = (cfg_load.data[31:16] != ~cfg_load.data[15:0] || al < base_minimum) ? base_minimum : al;
   assign want_dbg = cfg_load.data[31:24] == ~cfg_load.data[15:8] && cfg_load.data[15:8] != debug_disable_code;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   // a load with no second load behind it, so the output shows that word
   sequence quiet_load(s);
      cfg_load.strobe && cfg_load.sel == s ##1 !cfg_load.strobe;
   endsequence
   AST_BASE_ALIGN: assert property (data_space_base[8:0] == 9'h0)
      else $error("base not aligned");
   AST_BASE_MIN: assert property (data_space_base >= base_minimum)
      else $error("base below minimum");
   AST_BASE_LOAD: assert property (quiet_load(idx_boundary) |=> data_space_base == $past(want_base, 2))
      else $error("base wrong after load");
   AST_DEBUG_LOAD: assert property (quiet_load(idx_debug_lock) |=> debug_port_enable == $past(want_dbg, 2))
      else $error("debug enable wrong");
   AST_DONE: assert property (flash_req.valid |=> access_done)
      else $error("no verdict");
   AST_DONE_ONLY: assert property (!flash_req.valid |=> !access_done)
      else $error("spurious verdict");
   AST_VERDICT_HOLD: assert property (!flash_req.valid |=> $stable(access_allowed))
      else $error("verdict moved");
   AST_READ_IDLE: assert property (!reg_rd |=> reg_rd_data == 32'h0)
      else $error("stray read data");
endmodule
bind flash_config_word_decoder flash_config_word_decoder_asserts chk (.core_clk(core_clk), .arst_n(arst_n),
   .cfg_load(cfg_load), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .flash_req(flash_req),
   .access_done(access_done), .access_allowed(access_allowed), .debug_port_enable(debug_port_enable),
   .data_space_base(data_space_base));

// ===== bench/test_flash_config_word_decoder.sv
// random and corner bench for the flash config word decoder
// drives every port itself; one clock, fixed latencies
`timescale 1ns/1ps
module test_flash_config_word_decoder import flash_cfg_pkg::*;;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_addr = 32'h0;
   logic [31:0] reg_wr_data = 32'h0;
   cfg_load_type cfg_load = '0;
   flash_req_type flash_req = '0;
   logic [31:0] reg_rd_data;
   logic access_done;
   logic access_allowed;
   logic debug_port_enable;
   logic [15:0] data_space_base;
   logic [31:0] words [6] = '{default: 32'h0};
   // sel 6 must be ignored, else the base would move to 1c00
   logic [34:0] corner [9] = '{35'h0ffff0000, 35'h0fe0001ff, 35'h0fc0003ff, 35'h00000ffff, 35'h001234567,
      35'h6e3ff1c00, 35'h1aaff5500, 35'h1abff5400, 35'h1aaff5400};
   logic user = 1'b1;
   logic [31:0] w;
   logic [2:0] s;
   int failures = 0;
   int compares = 0;
   flash_config_word_decoder dut (.core_clk(core_clk), .arst_n(arst_n), .cfg_load(cfg_load),
      .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
      .flash_req(flash_req), .access_done(access_done), .access_allowed(access_allowed),
      .debug_port_enable(debug_port_enable), .data_space_base(data_space_base));
   initial forever #20 core_clk = ~core_clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      if (failures == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function automatic logic [15:0] base_of(input logic [31:0] x);
      logic [15:0] a;
      a = x[15:0] & 16'hfe00;
      return (x[31:16] !== ~x[15:0] || a < 16'h0200) ? 16'h0200 : a;
   endfunction
   function automatic logic dbg_of(input logic [31:0] x);
      return x[31:24] === ~x[15:8] && x[15:8] !== debug_disable_code;
   endfunction
   function automatic logic [31:0] status_of();
      logic [31:0] r;
      r = {16'h0, base_of(words[0])};
      r[st_debug_enable_bit] = dbg_of(words[1]);
      r[st_boundary_ok_bit] = words[0][31:16] === ~words[0][15:0];
      r[st_debug_ok_bit] = words[1][31:24] === ~words[1][15:8];
      for (int i = 0; i < 4; i++)
         r[st_permit_ok_lsb + i] = words[2 + i][31:16] === ~words[2 + i][15:0];
      return r;
   endfunction
   task automatic load(input logic [2:0] sel, input logic [31:0] d);
      @(posedge core_clk);
      cfg_load <= {1'b1, sel, d};
      if (sel < 3'h6)
         words[sel] = d;
      @(posedge core_clk);
      cfg_load.strobe <= 1'b0;
      @(posedge core_clk);
      #1;
      check({16'h0, data_space_base}, {16'h0, base_of(words[0])});
      check({31'h0, debug_port_enable}, {31'h0, dbg_of(words[1])});
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      if (!wr)
         check(reg_rd_data, d);
   endtask
   task automatic acc(input logic wr, input logic [15:0] a);
      logic [31:0] x;
      logic [15:0] p;
      x = words[3'h2 + {wr, 1'b0} + a[15]];
      p = (x[31:16] === ~x[15:0]) ? x[15:0] : 16'h0;
      @(posedge core_clk);
      flash_req <= {1'b1, wr, a};
      @(posedge core_clk);
      flash_req.valid <= 1'b0;
      #1;
      check({31'h0, access_done}, 32'h1);
      check({31'h0, access_allowed}, {31'h0, !user || p[a[14:11]]});
   endtask
   initial
   begin
      void'($urandom(86));
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      bus(1'b0, off_control, 32'h1);
      bus(1'b0, off_debug_lock, 32'h0);
      acc(1'b0, 16'h7800);
      foreach (corner[k]) load(corner[k][34:32], corner[k][31:0]);
      repeat (80)
      begin
         s = 3'($urandom % 6);
         w = $urandom;
         if (w[20])
            w[31:16] = ~w[15:0];
         if (w[3])
            w[31:24] = ~w[15:8];
         load(s, w);
         bus(1'b0, (s < 3'h2) ? off_boundary + 32'(4 * s) : off_read_low + 32'(4 * (s - 3'h2)), words[s]);
         bus(1'b0, off_status, status_of());
         acc(1'($urandom), 16'($urandom));
         acc(1'($urandom), 16'($urandom));
      end
      // config words are read-only, unmapped reads give zero
      bus(1'b1, off_read_low, 32'h0);
      bus(1'b0, off_read_low, words[2]);
      bus(1'b0, 32'h0030_0400, 32'h0);
      bus(1'b1, off_control, 32'h0);
      user = 1'b0;
      bus(1'b0, off_control, 32'h0);
      acc(1'b1, 16'hf800);
      acc(1'b0, 16'h0000);
      // reset in mid-run clears the words and puts user mode back
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      words = '{default: 32'h0};
      user = 1'b1;
      #1;
      check({16'h0, data_space_base}, {16'h0, base_minimum});
      check({31'h0, debug_port_enable}, 32'h0);
      bus(1'b0, off_control, 32'h1);
      bus(1'b0, off_status, status_of());
      acc(1'b0, 16'h0000);
      summarize;
   end
endmodule
